// ==== hdl/adcr_bank.v ====
// Control register bank of a stereo audio converter.
// Assumes the serial control front end delivers decoded one-cycle
// read and write strobes with address and data, synchronous to sys_clk.
//
// Functional notes
// - Eight 16-bit registers at addresses zero to seven.
// - Any write to register zero resets everything.
// - Register zero reads a fixed identification code.
// - Register one reads fixed three-bit revision.
// - Two-bit power state field, reset off.
// - De-emphasis bit eight, reset clear.
// - Master select bit seven; bit-clock edge/invert.
// - Frame invert, or DSP variant select.
// - Word length field selects 16/20/24/32 bits.
// - Format field picks four framings, reset I2S.
// - Output mix field selects stereo/mono/average.
// - Update bit applies both stored volumes together.
// - Volume codes above maximum saturate at top.
`timescale 1ns/1ps
`include "adcr_defs.vh"

module adcr_bank #(
    parameter [15:0] DEVICE_IDENTIFIER = 16'h5A5A, // Arbitrary value.
    parameter [2:0]  SILICON_REVISION  = 3'h2      // Arbitrary value.
) (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        wr_stb,
    input  wire        rd_stb,
    input  wire [2:0]  reg_addr,
    input  wire [15:0] wr_data,
    output reg  [15:0] rd_data_r,
    output reg         rd_valid_r,
    output reg  [1:0]  power_state_select_r,
    output reg         deemphasis_on_r,
    output reg         port_master_select_r,
    output reg         frame_clock_invert_r,
    output reg         dsp_first_clock_r,
    output reg         bclk_sample_falling_r,
    output reg         bclk_out_invert_r,
    output reg  [5:0]  word_bits_r,
    output reg  [1:0]  port_format_select_r,
    output reg  [1:0]  output_mix_select_r,
    output reg  [2:0]  bclk_divider_r,
    output reg  [2:0]  clock_ratio_r,
    output reg         zero_cross_on_r,
    output reg         right_mute_r,
    output reg         left_mute_r,
    output reg         ramp_up_r,
    output reg         ramp_down_r,
    output reg  [8:0]  left_volume_code_r,
    output reg  [8:0]  right_volume_code_r,
    output reg         volume_apply_r
);

    // ============================================================
    // Defaults and write filtering
    // ============================================================
    wire [16*`ADCR_NUM_REGS-1:0] flat;       // Live register contents.
    wire [15:0]                  mem_rd;     // Registered array read.
    reg  [15:0]                  wmask;      // Writable bits per address.
    wire                         soft_rst;   // Write to register zero.
    wire                         wr_ok;      // Write that stores data.
    reg  [2:0]                   rd_addr_r;  // Address of pending read.

    // Identity and revision entries are held at zero; their read value
    // is generated, so the array never stores them.
    // The array also resets to this image, so a read straight after
    // reset_n already shows every documented default.
    localparam [16*`ADCR_NUM_REGS-1:0] DEFAULT_IMAGE = {
        `ADCR_RST_VOL, `ADCR_RST_VOL, `ADCR_RST_MUTE,
        `ADCR_RST_MIX, `ADCR_RST_FMT, `ADCR_RST_PWR,
        16'h0000, 16'h0000};

    // Any write to address zero is a soft reset, whatever the data.
    assign soft_rst = wr_stb && reg_addr == `ADCR_A_IDENT;

    // Revision writes are dropped; the identity address only resets.
    assign wr_ok = wr_stb && reg_addr != `ADCR_A_IDENT &&
                   reg_addr != `ADCR_A_REV;

    // Bits the map leaves undefined are masked off at write time, so
    // stray ones from a careless host never read back.
    always @* begin
        case (reg_addr)
            `ADCR_A_PWR:  wmask = `ADCR_MSK_PWR;
            `ADCR_A_FMT:  wmask = `ADCR_MSK_FMT;
            `ADCR_A_MIX:  wmask = `ADCR_MSK_MIX;
            `ADCR_A_MUTE: wmask = `ADCR_MSK_MUTE;
            `ADCR_A_LVOL: wmask = `ADCR_MSK_VOL;
            `ADCR_A_RVOL: wmask = `ADCR_MSK_VOL;
            default:      wmask = 16'h0000;
        endcase
    end

    // ============================================================
    // Storage array
    // ============================================================
    // The clear is applied in the strobe's own cycle, so the very next
    // access already sees defaults.
    adcr_regmem #(
        .AW (`ADCR_ADDR_W),
        .DW (`ADCR_DATA_W),
        .N  (`ADCR_NUM_REGS),
        .DEFAULTS (DEFAULT_IMAGE)
    ) u_mem (
        .sys_clk   (sys_clk),
        .reset_n   (reset_n),
        .clear     (soft_rst),
        .wr_en     (wr_ok),
        .wr_addr   (reg_addr),
        .wr_data   (wr_data & wmask),
        .rd_addr   (reg_addr),
        .rd_data_r (mem_rd),
        .flat      (flat)
    );

    // ============================================================
    // Read path
    // ============================================================
    // A read answers two cycles after its strobe: one for the array's
    // registered output and one for the output register.
    reg rd_pend_r;  // Read strobe delayed by one cycle.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_pend_r  <= 1'b0;
            rd_addr_r  <= 3'h0;
            rd_valid_r <= 1'b0;
            rd_data_r  <= 16'h0000;
        end else begin
            rd_pend_r  <= rd_stb;
            rd_addr_r  <= reg_addr;
            rd_valid_r <= rd_pend_r;
            if (rd_pend_r) begin
                case (rd_addr_r)
                    `ADCR_A_IDENT: rd_data_r <= DEVICE_IDENTIFIER;
                    `ADCR_A_REV:   rd_data_r <= {13'h0000,
                                                 SILICON_REVISION};
                    default:       rd_data_r <= mem_rd;
                endcase
            end
        end
    end

    // ============================================================
    // Decoded control outputs
    // ============================================================
    // Decode straight from the array; it holds defaults from reset on,
    // so no separate power-on image is needed.
    wire [15:0] pwr  = flat[16*2 +: 16];
    wire [15:0] fmt  = flat[16*3 +: 16];
    wire [15:0] mix  = flat[16*4 +: 16];
    wire [15:0] mute = flat[16*5 +: 16];
    wire [15:0] lvol = flat[16*6 +: 16];
    wire [15:0] rvol = flat[16*7 +: 16];
    wire        dsp  = fmt[`ADCR_F_FMT_HI:0] == `ADCR_FMT_DSP;

    // Saturate a volume code at the top of the range.
    function [8:0] sat_vol;
        input [8:0] code;
        begin
            sat_vol = (code > `ADCR_VOL_MAX) ?
                      (`ADCR_VOL_MAX + 9'h001) : code;
        end
    endfunction

    // Update strobe from a volume write carrying the update bit.
    wire vol_wr = wr_ok && (reg_addr == `ADCR_A_LVOL ||
                  reg_addr == `ADCR_A_RVOL) && wr_data[`ADCR_F_VU];

    // Applied volumes move together only on an update or a soft reset; the
    // written value is taken from the bus since the array lags a cycle.
    reg [8:0] lv_apply;  // Left code that will be applied.
    reg [8:0] rv_apply;  // Right code that will be applied.
    always @* begin
        lv_apply = lvol[`ADCR_F_VOL_HI:0];
        rv_apply = rvol[`ADCR_F_VOL_HI:0];
        if (reg_addr == `ADCR_A_LVOL) begin
            lv_apply = wr_data[`ADCR_F_VOL_HI:0];
        end else begin
            rv_apply = wr_data[`ADCR_F_VOL_HI:0];
        end
    end

    // Registered decode of every control field.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            power_state_select_r  <= 2'h0;
            deemphasis_on_r       <= 1'b0;
            port_master_select_r  <= 1'b0;
            frame_clock_invert_r  <= 1'b0;
            dsp_first_clock_r     <= 1'b0;
            bclk_sample_falling_r <= 1'b0;
            bclk_out_invert_r     <= 1'b0;
            word_bits_r           <= 6'h18;
            port_format_select_r  <= 2'h2;
            output_mix_select_r   <= 2'h0;
            bclk_divider_r        <= 3'h0;
            clock_ratio_r         <= 3'h0;
            zero_cross_on_r       <= 1'b0;
            right_mute_r          <= 1'b0;
            left_mute_r           <= 1'b0;
            ramp_up_r             <= 1'b0;
            ramp_down_r           <= 1'b1;
            left_volume_code_r    <= `ADCR_RST_VOL_CODE;
            right_volume_code_r   <= `ADCR_RST_VOL_CODE;
            volume_apply_r        <= 1'b0;
        end else begin
            power_state_select_r  <= pwr[`ADCR_F_PWR_HI:0];
            deemphasis_on_r       <= fmt[`ADCR_F_DEEMP];
            port_master_select_r  <= fmt[`ADCR_F_MASTER];
            bclk_sample_falling_r <= ~fmt[`ADCR_F_MASTER] &
                                     fmt[`ADCR_F_BIT_INV];
            bclk_out_invert_r     <= fmt[`ADCR_F_MASTER] &
                                     fmt[`ADCR_F_BIT_INV];
            frame_clock_invert_r  <= ~dsp & fmt[`ADCR_F_FRAME_INV];
            dsp_first_clock_r     <= dsp & fmt[`ADCR_F_FRAME_INV];
            case (fmt[`ADCR_F_WL_HI:`ADCR_F_WL_LO])
                2'h0:    word_bits_r <= 6'h10;
                2'h1:    word_bits_r <= 6'h14;
                2'h2:    word_bits_r <= 6'h18;
                default: word_bits_r <= 6'h20;
            endcase
            port_format_select_r  <= fmt[`ADCR_F_FMT_HI:0];
            output_mix_select_r   <= mix[`ADCR_F_MIX_HI:`ADCR_F_MIX_LO];
            bclk_divider_r        <= mix[`ADCR_F_BDIV_HI:`ADCR_F_BDIV_LO];
            clock_ratio_r         <= mix[`ADCR_F_RATIO_HI:0];
            zero_cross_on_r       <= mute[`ADCR_F_ZC];
            right_mute_r          <= mute[`ADCR_F_RMUTE];
            left_mute_r           <= mute[`ADCR_F_LMUTE];
            ramp_up_r             <= mute[`ADCR_F_UPRAMP];
            ramp_down_r           <= mute[`ADCR_F_DNRAMP];
            volume_apply_r        <= vol_wr;
            if (soft_rst) begin
                left_volume_code_r  <= `ADCR_RST_VOL_CODE;
                right_volume_code_r <= `ADCR_RST_VOL_CODE;
            end else if (vol_wr) begin
                left_volume_code_r  <= sat_vol(lv_apply);
                right_volume_code_r <= sat_vol(rv_apply);
            end
        end
    end

endmodule // adcr_bank

// ==== hdl/adcr_defs.vh ====
// Constants for the audio converter control register bank.
// Assumes inclusion by bare name from the design files under hdl/.
`ifndef ADCR_DEFS_VH
`define ADCR_DEFS_VH

// ============================================================
// Register addresses
// ============================================================
`define ADCR_ADDR_W          3
`define ADCR_DATA_W          16
`define ADCR_NUM_REGS        8
`define ADCR_A_IDENT         3'h0
`define ADCR_A_REV           3'h1
`define ADCR_A_PWR           3'h2
`define ADCR_A_FMT           3'h3
`define ADCR_A_MIX           3'h4
`define ADCR_A_MUTE          3'h5
`define ADCR_A_LVOL          3'h6
`define ADCR_A_RVOL          3'h7

// ============================================================
// Reset values and writable-bit masks
// ============================================================
`define ADCR_RST_PWR         16'h0000
`define ADCR_RST_FMT         16'h1812
`define ADCR_RST_MIX         16'h0000
`define ADCR_RST_MUTE        16'h0001
`define ADCR_RST_VOL         16'h0190
`define ADCR_RST_VOL_CODE    9'h190
`define ADCR_MSK_PWR         16'h0003
`define ADCR_MSK_FMT         16'h01FB
`define ADCR_MSK_MIX         16'h00FF
`define ADCR_MSK_MUTE        16'h001F
`define ADCR_MSK_VOL         16'h03FF
`define ADCR_MSK_REV         16'h0007

// ============================================================
// Field positions
// ============================================================
`define ADCR_F_PWR_HI        1
`define ADCR_F_DEEMP         8
`define ADCR_F_MASTER        7
`define ADCR_F_FRAME_INV     6
`define ADCR_F_BIT_INV       5
`define ADCR_F_WL_HI         4
`define ADCR_F_WL_LO         3
`define ADCR_F_FMT_HI        1
`define ADCR_F_MIX_HI        7
`define ADCR_F_MIX_LO        6
`define ADCR_F_BDIV_HI       5
`define ADCR_F_BDIV_LO       3
`define ADCR_F_RATIO_HI      2
`define ADCR_F_ZC            4
`define ADCR_F_RMUTE         3
`define ADCR_F_LMUTE         2
`define ADCR_F_UPRAMP        1
`define ADCR_F_DNRAMP        0
`define ADCR_F_VU            9
`define ADCR_F_VOL_HI        8

// ============================================================
// Encodings
// ============================================================
`define ADCR_FMT_DSP         2'h3
`define ADCR_VOL_MAX         9'h1BE

`endif

// ==== hdl/adcr_regmem.v ====
// Small register array of the control bank, with registered read data.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps

// ============================================================
// Eight-entry storage with reset-to-default
// ============================================================
module adcr_regmem #(
    parameter AW = 3,
    parameter DW = 16,
    parameter N  = 8,
    parameter [N*DW-1:0] DEFAULTS = {N*DW{1'b0}}
) (
    input  wire                 sys_clk,
    input  wire                 reset_n,
    input  wire                 clear,
    input  wire                 wr_en,
    input  wire [AW-1:0]        wr_addr,
    input  wire [DW-1:0]        wr_data,
    input  wire [AW-1:0]        rd_addr,
    output reg  [DW-1:0]        rd_data_r,
    output wire [N*DW-1:0]      flat
);

    reg [DW-1:0] mem_r [0:N-1];     // Stored register words.

    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_ent
            // Each entry loads its default on reset or on the clear
            // strobe; clear wins over a write so that a soft reset
            // always leaves a clean bank.
            always @(posedge sys_clk or negedge reset_n) begin
                if (!reset_n) begin
                    mem_r[g] <= DEFAULTS[g*DW +: DW];
                end else if (clear) begin
                    mem_r[g] <= DEFAULTS[g*DW +: DW];
                end else if (wr_en && wr_addr == g) begin
                    mem_r[g] <= wr_data;
                end
            end
            assign flat[g*DW +: DW] = mem_r[g];
        end
    endgenerate

    // Read data comes out of a register, one cycle after the address.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_r <= {DW{1'b0}};
        end else begin
            rd_data_r <= mem_r[rd_addr];
        end
    end

endmodule // adcr_regmem

// ==== test/adcr_bank_props.sv ====
// Concurrent checks on the control register bank ports.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps

// ============================================================
// Checker
// ============================================================
module adcr_bank_props #(
    parameter [15:0] DEVICE_IDENTIFIER = 16'h5A5A, // Arbitrary value.
    parameter [2:0]  SILICON_REVISION  = 3'h2      // Arbitrary value.
) (
    input wire        sys_clk,
    input wire        reset_n,
    input wire        wr_stb,
    input wire        rd_stb,
    input wire [2:0]  reg_addr,
    input wire [15:0] wr_data,
    input wire [15:0] rd_data_r,
    input wire        rd_valid_r,
    input wire [1:0]  power_state_select_r,
    input wire        deemphasis_on_r,
    input wire        port_master_select_r,
    input wire        frame_clock_invert_r,
    input wire        dsp_first_clock_r,
    input wire        bclk_sample_falling_r,
    input wire        bclk_out_invert_r,
    input wire [5:0]  word_bits_r,
    input wire [1:0]  port_format_select_r,
    input wire [1:0]  output_mix_select_r,
    input wire        ramp_down_r,
    input wire [8:0]  left_volume_code_r,
    input wire [8:0]  right_volume_code_r,
    input wire        volume_apply_r
);
    // All checks share the one clock and are quiet while in reset.
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // A write to the format register sets the width two edges later.
    property p_width;
        wr_stb && reg_addr == 3'h3 |-> ##2 word_bits_r ==
            (($past(wr_data[4:3], 2) == 2'h3) ? 6'h20 :
             6'h10 + {2'h0, $past(wr_data[4:3], 2), 2'h0});
    endproperty

    AST_RD_LAT: assert property (rd_stb |-> ##2 rd_valid_r)
        else $error("read answer missing");
    AST_RD_CAUSE: assert property (rd_valid_r |-> $past(rd_stb, 2))
        else $error("read answer without a request");
    AST_ID: assert property (rd_stb && reg_addr == 3'h0 |->
        ##2 rd_data_r == DEVICE_IDENTIFIER) else $error("bad identifier");
    AST_REV: assert property (rd_stb && reg_addr == 3'h1 |->
        ##2 rd_data_r == {13'h0000, SILICON_REVISION})
        else $error("bad revision");
    AST_SOFT_RST: assert property (wr_stb && reg_addr == 3'h0 |->
        ##2 (power_state_select_r == 2'h0 && word_bits_r == 6'h18 &&
        port_format_select_r == 2'h2 && ramp_down_r &&
        left_volume_code_r == 9'h190)) else $error("no soft reset");
    AST_PWR: assert property (wr_stb && reg_addr == 3'h2 |->
        ##2 power_state_select_r == $past(wr_data[1:0], 2))
        else $error("power field wrong");
    AST_FMT: assert property (wr_stb && reg_addr == 3'h3 |->
        ##2 (port_format_select_r == $past(wr_data[1:0], 2) &&
        deemphasis_on_r == $past(wr_data[8], 2) &&
        port_master_select_r == $past(wr_data[7], 2)))
        else $error("format fields wrong");
    AST_WIDTH: assert property (p_width)
        else $error("word width wrong");
    AST_FRAME: assert property (!(frame_clock_invert_r &&
        port_format_select_r == 2'h3) && !(dsp_first_clock_r &&
        port_format_select_r != 2'h3)) else $error("frame bit misrouted");
    AST_BCLK: assert property (!(bclk_sample_falling_r &&
        port_master_select_r) && !(bclk_out_invert_r &&
        !port_master_select_r)) else $error("bit clock bit misrouted");
    AST_MIX: assert property (wr_stb && reg_addr == 3'h4 |->
        ##2 output_mix_select_r == $past(wr_data[7:6], 2))
        else $error("mix field wrong");
    AST_VU: assert property (wr_stb && reg_addr[2:1] == 2'h3 &&
        wr_data[9] |=> volume_apply_r) else $error("no volume apply");
    AST_NO_VU: assert property (wr_stb && reg_addr == 3'h6 &&
        !wr_data[9] |=> $stable(left_volume_code_r))
        else $error("volume applied without update");
    AST_SAT: assert property (left_volume_code_r <= 9'h1BF &&
        right_volume_code_r <= 9'h1BF) else $error("volume not saturated");

    // Main scenarios reached.
    COV_ID: cover property (rd_stb && reg_addr == 3'h0);
    COV_RST: cover property (wr_stb && reg_addr == 3'h0);
    COV_VU: cover property (volume_apply_r);
endmodule // adcr_bank_props

bind adcr_bank adcr_bank_props #(
    .DEVICE_IDENTIFIER(DEVICE_IDENTIFIER),
    .SILICON_REVISION(SILICON_REVISION)
) u_props (.sys_clk, .reset_n, .wr_stb, .rd_stb, .reg_addr, .wr_data,
    .rd_data_r, .rd_valid_r, .power_state_select_r, .deemphasis_on_r,
    .port_master_select_r, .frame_clock_invert_r, .dsp_first_clock_r,
    .bclk_sample_falling_r, .bclk_out_invert_r, .word_bits_r,
    .port_format_select_r, .output_mix_select_r, .ramp_down_r,
    .left_volume_code_r, .right_volume_code_r, .volume_apply_r);

// ==== test/adcr_bank_tb.sv ====
// Self-checking bench for the control register bank.
// Assumes the host model drives every bank input except sys_clk and reset_n.
`timescale 1ns/1ps

module adcr_bank_tb;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    wire wr_stb, rd_stb, rd_valid_r, deemph, master, frame_inv, dsp_first;
    wire bclk_fall, bclk_inv, ramp_dn, vol_apply;
    wire zc, rmute, lmute, ramp_up;
    wire [2:0]  reg_addr, bdiv, ratio;
    wire [15:0] wr_data, rd_data_r;
    wire [1:0]  pwr, fmt, mix;
    wire [5:0]  wbits;
    wire [8:0]  lvol, rvol;
    logic [15:0] v;
    int n_fail = 0;
    int n_tests = 0;
    logic [15:0] dflt [0:7] = '{16'h0, 16'h0, 16'h0000, 16'h1812,
                                16'h0000, 16'h0001, 16'h0190, 16'h0190};
    logic [5:0]  widths [0:3] = '{6'h10, 6'h14, 6'h18, 6'h20};

    always #5 sys_clk = ~sys_clk;

    adcr_bank uut (.sys_clk, .reset_n, .wr_stb, .rd_stb, .reg_addr,
        .wr_data, .rd_data_r, .rd_valid_r, .power_state_select_r(pwr),
        .deemphasis_on_r(deemph), .port_master_select_r(master),
        .frame_clock_invert_r(frame_inv), .dsp_first_clock_r(dsp_first),
        .bclk_sample_falling_r(bclk_fall), .bclk_out_invert_r(bclk_inv),
        .word_bits_r(wbits), .port_format_select_r(fmt),
        .output_mix_select_r(mix), .bclk_divider_r(bdiv),
        .clock_ratio_r(ratio), .zero_cross_on_r(zc),
        .right_mute_r(rmute), .left_mute_r(lmute), .ramp_up_r(ramp_up),
        .ramp_down_r(ramp_dn), .left_volume_code_r(lvol),
        .right_volume_code_r(rvol), .volume_apply_r(vol_apply));

    adcr_host_model host (.sys_clk, .rd_data_r, .rd_valid_r, .wr_stb,
        .rd_stb, .reg_addr, .wr_data);

    // One comparison; a mismatch is reported and counted at once.
    task automatic chk(input string nm, input [15:0] got, input [15:0] ex);
        n_tests++;
        if (got !== ex) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // Decoded outputs follow a write two edges later.
    task automatic settle();
        repeat (2) @(posedge sys_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // Watchdog: the tests need well under a thousand cycles.
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        settle();
        chk("power", 16'(pwr), 16'h0);
        chk("format", 16'(fmt), 16'h2);
        chk("width", 16'(wbits), 16'h18);
        chk("lvol", 16'(lvol), 16'h190);
        // Stored defaults read back before any write at all.
        host.rd(3'h3, v);
        chk("fmtrst", v, 16'h1812);
        host.rd(3'h5, v);
        chk("muterst", v, 16'h0001);
        host.rd(3'h0, v);
        chk("ident", v, 16'h5A5A);
        host.wr(3'h1, 16'hFFFF);
        host.rd(3'h1, v);
        chk("rev", v, 16'h0002);
        // Soft reset, then registers two to seven read their defaults.
        host.wr(3'h0, 16'h1234);
        for (int i = 2; i < 8; i++) begin
            host.rd(3'(i), v);
            chk("dflt", v, dflt[i]);
        end
        for (int i = 0; i < 4; i++) begin
            host.wr(3'h2, 16'(i));
            settle();
            chk("power", 16'(pwr), 16'(i));
            host.wr(3'h3, 16'(i << 3) | 16'h0002);
            settle();
            chk("width", 16'(wbits), 16'(widths[i]));
            host.wr(3'h3, 16'h0040 | 16'(i));
            settle();
            chk("format", 16'(fmt), 16'(i));
            chk("frameinv", 16'(frame_inv), 16'(i != 3));
            chk("dspfirst", 16'(dsp_first), 16'(i == 3));
            host.wr(3'h4, 16'(i << 6) | 16'(i << 3) | 16'(i));
            settle();
            chk("mix", 16'(mix), 16'(i));
            chk("bdiv", 16'(bdiv), 16'(i));
            chk("ratio", 16'(ratio), 16'(i));
        end
        for (int m = 0; m < 2; m++) begin
            host.wr(3'h3, 16'h0122 | 16'(m << 7));
            settle();
            chk("master", 16'(master), 16'(m));
            chk("bclkfall", 16'(bclk_fall), 16'(m == 0));
            chk("bclkinv", 16'(bclk_inv), 16'(m));
            chk("deemph", 16'(deemph), 16'h1);
        end
        // Undefined and reserved positions read back as zero.
        host.wr(3'h3, 16'hFFFF);
        host.rd(3'h3, v);
        chk("fmtmask", v, 16'h01FB);
        host.wr(3'h5, 16'hFFFF);
        host.rd(3'h5, v);
        chk("mutemask", v, 16'h001F);
        chk("mutebits", 16'({zc, rmute, lmute, ramp_up, ramp_dn}),
            16'h001F);
        // Stored volume stays unapplied until an update write.
        host.wr(3'h6, 16'h01C0);
        settle();
        chk("lvol", 16'(lvol), 16'h190);
        host.rd(3'h6, v);
        chk("lstore", v, 16'h01C0);
        host.wr(3'h7, 16'h02A0);
        settle();
        chk("lvol", 16'(lvol), 16'h1BF);
        chk("rvol", 16'(rvol), 16'h0A0);
        tally_and_finish();
    end
endmodule // adcr_bank_tb

// ==== test/adcr_host_model.sv ====
// Host side of the control interface: one-cycle strobes per access.
// Assumes the bench calls its tasks only after reset is released.
`timescale 1ns/1ps

// ============================================================
// Host model
// ============================================================
module adcr_host_model (
    input  wire        sys_clk,
    input  wire [15:0] rd_data_r,
    input  wire        rd_valid_r,
    output logic       wr_stb   = 1'b0,
    output logic       rd_stb   = 1'b0,
    output logic [2:0] reg_addr = 3'h0,
    output logic [15:0] wr_data = 16'h0000
);
    // Writes only the eight defined addresses; the bench passes zeros
    // in undefined bits except where it probes masking on purpose.
    task automatic wr(input [2:0] a, input [15:0] d);
        @(posedge sys_clk);
        wr_stb   <= 1'b1;
        reg_addr <= a;
        wr_data  <= d;
        @(posedge sys_clk);
        wr_stb   <= 1'b0;
        // Released lines show a changed value, so stale data never helps.
        reg_addr <= ~a;
        wr_data  <= ~d;
    endtask

    // Read answer is awaited under a bounded count.
    task automatic rd(input [2:0] a, output logic [15:0] v);
        @(posedge sys_clk);
        rd_stb   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        rd_stb   <= 1'b0;
        reg_addr <= ~a;
        v = 16'hXXXX;
        repeat (4) begin
            @(posedge sys_clk);
            #1;
            if (rd_valid_r === 1'b1) begin
                v = rd_data_r;
                break;
            end
        end
    endtask
endmodule // adcr_host_model
